// [pfs_pin_mux.sv]
// pin function sharing top: port muxing, lcd planes, bus clock divider
// What this block does
// - The bus clock toggles on every rising edge of the selected oscillator input, halving it.
// - Driving the active-low reset low puts every control register in its start-up value.
// - The first port is eight software-controlled lines, all inputs after reset.
// - First port: key wake-up 0-3, buzzer 3, analog 4-5, events 4, carrier 6, pulse width 7.
// - Third-port bits 0-2 carry SPI clock, data out and data in, and bit 3 the interrupt request.
// - All third-port lines come up as plain port inputs and are otherwise software controlled.
// - Each third-port pin has its own software pull-up enable.
// - The SPI clock and data-out pins can be switched to open-drain drive.
// - Second-port lines start as LCD front-plane outputs and can be handed to port use.
// - Front planes 17 to 24 land on second-port bits 7 down to 0.
// - There are 25 front-plane outputs and front plane 0 shares its pin with back plane 3.
// - There are four back planes and back plane 3 shares the front plane 0 pin.
// - The interrupt pin on third-port bit 3 also selects special mode entry.
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_mux
  import pfs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cfg_wr,
  input wire pfs_cfg_t cfg_sel,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] first_port_read,
  output logic [7:0] second_port_read,
  output logic [3:0] third_port_read,
  input wire logic [7:0] first_port_line_in,
  output logic [7:0] first_port_line_out,
  output logic [7:0] first_port_line_oe,
  input wire logic [7:0] second_port_line_in,
  output logic [7:0] second_port_line_out,
  output logic [7:0] second_port_line_oe,
  input wire logic [3:0] third_port_line_in,
  output logic [3:0] third_port_line_out,
  output logic [3:0] third_port_line_oe,
  output logic [3:0] third_port_pullup_en,
  output logic [3:0] key_wakeup_input,
  input wire logic buzzer_enable,
  input wire logic buzzer_tone_output,
  input wire logic analog_input_zero_sel,
  input wire logic analog_input_one_sel,
  output logic event_count_input,
  input wire logic remote_enable,
  input wire logic remote_carrier_output,
  output logic pulse_width_input,
  input wire logic spi_enable,
  input wire logic spi_sck_out,
  input wire logic spi_sck_oe,
  input wire logic spi_sdo_out,
  input wire logic spi_sdo_oe,
  output logic spi_sdi_in,
  input wire logic irq_enable,
  output logic irq_request_b,
  output logic special_mode_select,
  input wire logic [24:0] lcd_front_plane,
  input wire logic [3:0] lcd_back_plane,
  input wire logic lcd_quarter_duty,
  output logic [15:0] lcd_front_plane_pin,
  output logic [2:0] lcd_back_plane_pin,
  output logic lcd_shared_plane_pin,
  input wire logic main_osc_input,
  input wire logic secondary_osc_input,
  input wire logic osc_select,
  output logic bus_frequency_clk
);

  logic [7:0] a_data_reg;
  logic [7:0] a_data_next;
  logic [7:0] a_dir_reg;
  logic [7:0] a_dir_next;
  logic [7:0] b_data_reg;
  logic [7:0] b_data_next;
  logic [7:0] b_dir_reg;
  logic [7:0] b_dir_next;
  logic [7:0] b_lcd_reg;
  logic [7:0] b_lcd_next;
  logic [3:0] c_data_reg;
  logic [3:0] c_data_next;
  logic [3:0] c_dir_reg;
  logic [3:0] c_dir_next;
  logic [3:0] c_pull_reg;
  logic [3:0] c_pull_next;
  logic [1:0] od_reg;
  logic [1:0] od_next;
  logic [2:0] mode_cnt_reg;
  logic [2:0] mode_cnt_next;
  logic special_reg;
  logic special_next;
  logic osc_prev_reg;
  logic bus_clk_reg;
  logic bus_clk_next;

  logic [7:0] a_per_en;
  logic [7:0] a_per_out;
  logic [7:0] a_per_oe;
  logic [3:0] c_per_en;
  logic [3:0] c_per_out;
  logic [3:0] c_per_oe;
  logic [3:0] c_mux_out;
  logic [3:0] c_mux_oe;
  logic [3:0] c_od_mask;
  logic [7:0] b_fp_drive;
  logic osc_level;
  logic osc_rise;
  logic mode_capture;
  logic mode_done;
  logic sel_a_data;
  logic sel_a_dir;
  logic sel_b_data;
  logic sel_b_dir;
  logic sel_b_lcd;
  logic sel_c_data;
  logic sel_c_dir;
  logic sel_c_pull;
  logic sel_od;

  pfs_sync_if #(.W(PFS_SYNC_W)) sy ();

  pfs_pin_sync #(.W(PFS_SYNC_W)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sy(sy.snk)
  );

  // every pin and oscillator lane passes the synchroniser
  assign sy.raw = {secondary_osc_input, main_osc_input, third_port_line_in,
                   second_port_line_in, first_port_line_in};

  // configuration select decode
  assign sel_a_data = cfg_wr && (cfg_sel == PFS_CFG_A_DATA);
  assign sel_a_dir = cfg_wr && (cfg_sel == PFS_CFG_A_DIR);
  assign sel_b_data = cfg_wr && (cfg_sel == PFS_CFG_B_DATA);
  assign sel_b_dir = cfg_wr && (cfg_sel == PFS_CFG_B_DIR);
  assign sel_b_lcd = cfg_wr && (cfg_sel == PFS_CFG_B_LCD);
  assign sel_c_data = cfg_wr && (cfg_sel == PFS_CFG_C_DATA);
  assign sel_c_dir = cfg_wr && (cfg_sel == PFS_CFG_C_DIR);
  assign sel_c_pull = cfg_wr && (cfg_sel == PFS_CFG_C_PULL);
  assign sel_od = cfg_wr && (cfg_sel == PFS_CFG_OD);

  // configuration loads
  assign a_data_next = sel_a_data ? cfg_wdata : a_data_reg;
  assign a_dir_next = sel_a_dir ? cfg_wdata : a_dir_reg;
  assign b_data_next = sel_b_data ? cfg_wdata : b_data_reg;
  assign b_dir_next = sel_b_dir ? cfg_wdata : b_dir_reg;
  assign b_lcd_next = sel_b_lcd ? cfg_wdata : b_lcd_reg;
  assign c_data_next = sel_c_data ? cfg_wdata[3:0] : c_data_reg;
  assign c_dir_next = sel_c_dir ? cfg_wdata[3:0] : c_dir_reg;
  assign c_pull_next = sel_c_pull ? cfg_wdata[3:0] : c_pull_reg;
  assign od_next = sel_od ? cfg_wdata[1:0] : od_reg;

  // first port peripheral ownership
  always_comb
  begin
    a_per_en = 8'h00;
    a_per_out = 8'h00;
    a_per_oe = 8'h00;
    a_per_en[PFS_A_BUZZ_BIT] = buzzer_enable;
    a_per_out[PFS_A_BUZZ_BIT] = buzzer_tone_output;
    a_per_oe[PFS_A_BUZZ_BIT] = 1'b1;
    a_per_en[PFS_A_AN0_BIT] = analog_input_zero_sel;
    a_per_en[PFS_A_AN1_BIT] = analog_input_one_sel;
    a_per_en[PFS_A_REMOTE_BIT] = remote_enable;
    a_per_out[PFS_A_REMOTE_BIT] = remote_carrier_output;
    a_per_oe[PFS_A_REMOTE_BIT] = 1'b1;
  end

  // third port peripheral ownership
  always_comb
  begin
    c_per_en = 4'h0;
    c_per_out = 4'h0;
    c_per_oe = 4'h0;
    c_per_en[PFS_C_SCK_BIT] = spi_enable;
    c_per_out[PFS_C_SCK_BIT] = spi_sck_out;
    c_per_oe[PFS_C_SCK_BIT] = spi_sck_oe;
    c_per_en[PFS_C_SDO_BIT] = spi_enable;
    c_per_out[PFS_C_SDO_BIT] = spi_sdo_out;
    c_per_oe[PFS_C_SDO_BIT] = spi_sdo_oe;
    c_per_en[PFS_C_SDI_BIT] = spi_enable;
    c_per_en[PFS_C_IRQ_BIT] = irq_enable;
  end

  // open-drain applies to the spi clock and data-out pins only
  assign c_od_mask = {2'b00, od_reg} & c_per_en;

  genvar gi;

  // first and second port per-bit muxes
  generate
    for (gi = 0; gi < PFS_A_W; gi++)
    begin : g_ab
      assign first_port_line_out[gi] = a_per_en[gi] ? a_per_out[gi] : a_data_reg[gi];
      assign first_port_line_oe[gi] = a_per_en[gi] ? a_per_oe[gi] : a_dir_reg[gi];
      assign b_fp_drive[gi] = lcd_front_plane[PFS_FP_B_FIRST + PFS_B_W - 1 - gi];
      assign second_port_line_out[gi] = b_lcd_reg[gi] ? b_fp_drive[gi] : b_data_reg[gi];
      assign second_port_line_oe[gi] = b_lcd_reg[gi] ? 1'b1 : b_dir_reg[gi];
    end
  endgenerate

  // third port per-bit mux with open-drain reduction
  generate
    for (gi = 0; gi < PFS_C_W; gi++)
    begin : g_c
      assign c_mux_out[gi] = c_per_en[gi] ? c_per_out[gi] : c_data_reg[gi];
      assign c_mux_oe[gi] = c_per_en[gi] ? c_per_oe[gi] : c_dir_reg[gi];
      assign third_port_line_out[gi] = c_od_mask[gi] ? 1'b0 : c_mux_out[gi];
      assign third_port_line_oe[gi] = c_od_mask[gi] ? (c_mux_oe[gi] & ~c_mux_out[gi])
                                                    : c_mux_oe[gi];
    end
  endgenerate

  assign third_port_pullup_en = c_pull_reg;

  // reads and peripheral inputs from synchronised levels
  assign first_port_read = sy.level[PFS_SYNC_A_LSB +: PFS_A_W];
  assign second_port_read = sy.level[PFS_SYNC_B_LSB +: PFS_B_W];
  assign third_port_read = sy.level[PFS_SYNC_C_LSB +: PFS_C_W];
  assign key_wakeup_input = first_port_read[PFS_KWI_N-1:0];
  assign event_count_input = first_port_read[PFS_A_EVENT_BIT];
  assign pulse_width_input = first_port_read[PFS_A_PWC_BIT];
  assign spi_sdi_in = third_port_read[PFS_C_SDI_BIT];
  assign irq_request_b = third_port_read[PFS_C_IRQ_BIT];

  // lcd planes
  assign lcd_front_plane_pin = lcd_front_plane[PFS_FP_B_FIRST-1:1];
  assign lcd_back_plane_pin = lcd_back_plane[PFS_BP_SHARED-1:0];
  assign lcd_shared_plane_pin = lcd_quarter_duty ? lcd_back_plane[PFS_BP_SHARED]
                                                 : lcd_front_plane[PFS_FP_SHARED];

  // mode pin sampled once the synchroniser has settled
  // the read holds its reset value until four edges after release
  assign mode_capture = (mode_cnt_reg == PFS_MODE_CAPTURE_CYCLES);
  assign mode_done = (mode_cnt_reg == PFS_MODE_CAPTURE_CYCLES + 3'h1);
  assign mode_cnt_next = mode_done ? mode_cnt_reg : mode_cnt_reg + 3'h1;
  assign special_next = mode_capture ? ~third_port_read[PFS_C_IRQ_BIT] : special_reg;
  assign special_mode_select = special_reg;

  // bus clock: toggle on each rising oscillator edge
  assign osc_level = osc_select ? sy.level[PFS_SYNC_SEC_OSC] : sy.level[PFS_SYNC_MAIN_OSC];
  assign osc_rise = osc_level & ~osc_prev_reg;
  assign bus_clk_next = osc_rise ? ~bus_clk_reg : bus_clk_reg;
  assign bus_frequency_clk = bus_clk_reg;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      a_data_reg <= PFS_A_DATA_RST;
      a_dir_reg <= PFS_A_DIR_RST;
      b_data_reg <= PFS_B_DATA_RST;
      b_dir_reg <= PFS_B_DIR_RST;
      b_lcd_reg <= PFS_B_LCD_RST;
    end
    else
    begin
      a_data_reg <= a_data_next;
      a_dir_reg <= a_dir_next;
      b_data_reg <= b_data_next;
      b_dir_reg <= b_dir_next;
      b_lcd_reg <= b_lcd_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      c_data_reg <= PFS_C_DATA_RST;
      c_dir_reg <= PFS_C_DIR_RST;
      c_pull_reg <= PFS_C_PULL_RST;
      od_reg <= PFS_OD_RST;
    end
    else
    begin
      c_data_reg <= c_data_next;
      c_dir_reg <= c_dir_next;
      c_pull_reg <= c_pull_next;
      od_reg <= od_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_cnt_reg <= 3'h0;
      special_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
      bus_clk_reg <= 1'b0;
    end
    else
    begin
      mode_cnt_reg <= mode_cnt_next;
      special_reg <= special_next;
      osc_prev_reg <= osc_level;
      bus_clk_reg <= bus_clk_next;
    end
  end

endmodule
`default_nettype wire

// [pfs_pkg.sv]
// constants and types shared by the pin function sharing block
package pfs_pkg;

  localparam int unsigned PFS_A_W = 8;
  localparam int unsigned PFS_B_W = 8;
  localparam int unsigned PFS_C_W = 4;
  localparam int unsigned PFS_FP_N = 25;
  localparam int unsigned PFS_BP_N = 4;
  localparam int unsigned PFS_KWI_N = 4;

  // synchroniser lane layout
  localparam int unsigned PFS_SYNC_W = 22;
  localparam int unsigned PFS_SYNC_A_LSB = 0;
  localparam int unsigned PFS_SYNC_B_LSB = 8;
  localparam int unsigned PFS_SYNC_C_LSB = 16;
  localparam int unsigned PFS_SYNC_MAIN_OSC = 20;
  localparam int unsigned PFS_SYNC_SEC_OSC = 21;

  // first port shared bit positions
  localparam int unsigned PFS_A_BUZZ_BIT = 3;
  localparam int unsigned PFS_A_AN0_BIT = 4;
  localparam int unsigned PFS_A_EVENT_BIT = 4;
  localparam int unsigned PFS_A_AN1_BIT = 5;
  localparam int unsigned PFS_A_REMOTE_BIT = 6;
  localparam int unsigned PFS_A_PWC_BIT = 7;

  // third port shared bit positions
  localparam int unsigned PFS_C_SCK_BIT = 0;
  localparam int unsigned PFS_C_SDO_BIT = 1;
  localparam int unsigned PFS_C_SDI_BIT = 2;
  localparam int unsigned PFS_C_IRQ_BIT = 3;

  // lcd plane sharing
  localparam int unsigned PFS_FP_B_FIRST = 17;
  localparam int unsigned PFS_FP_SHARED = 0;
  localparam int unsigned PFS_BP_SHARED = 3;

  // reset values
  localparam logic [7:0] PFS_A_DATA_RST = 8'h00;
  localparam logic [7:0] PFS_A_DIR_RST = 8'h00;
  localparam logic [7:0] PFS_B_DATA_RST = 8'h00;
  localparam logic [7:0] PFS_B_DIR_RST = 8'h00;
  localparam logic [7:0] PFS_B_LCD_RST = 8'hff;
  localparam logic [3:0] PFS_C_DATA_RST = 4'h0;
  localparam logic [3:0] PFS_C_DIR_RST = 4'h0;
  localparam logic [3:0] PFS_C_PULL_RST = 4'h0;
  localparam logic [1:0] PFS_OD_RST = 2'h0;

  // cycles after reset release before the mode pin is sampled
  localparam logic [2:0] PFS_MODE_CAPTURE_CYCLES = 3'h4;

  typedef enum logic [8:0] {
    PFS_CFG_A_DATA = 9'h001,
    PFS_CFG_A_DIR = 9'h002,
    PFS_CFG_B_DATA = 9'h004,
    PFS_CFG_B_DIR = 9'h008,
    PFS_CFG_B_LCD = 9'h010,
    PFS_CFG_C_DATA = 9'h020,
    PFS_CFG_C_DIR = 9'h040,
    PFS_CFG_C_PULL = 9'h080,
    PFS_CFG_OD = 9'h100
  } pfs_cfg_t;

endpackage

// [pfs_sync_if.sv]
// carrier between pin sampling and the pin mux
`timescale 1ns/1ps
`default_nettype none
interface pfs_sync_if #(parameter int unsigned W = 22);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  modport src (output raw, input level);
  modport snk (input raw, output level);
endinterface
`default_nettype wire

// [pfs_pin_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_sync
  import pfs_pkg::*;
#(
  parameter int unsigned W = PFS_SYNC_W
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  pfs_sync_if.snk sy
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_reg;
  logic [W-1:0] level_next;

  // level moves only where stage two and three agree
  assign level_next = (s2_reg & s3_reg) | (level_reg & (s2_reg ^ s3_reg));
  assign sy.level = level_reg;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      level_reg <= '0;
    end
    else
    begin
      s1_reg <= sy.raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end

endmodule
`default_nettype wire

// [pfs_pin_mux_end.sv]
// empty unit with no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [pfs_pin_mux_asserts.sv]
// checker for the pin function sharing block
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_mux_asserts
  import pfs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cfg_wr,
  input wire pfs_cfg_t cfg_sel,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] first_port_read,
  input wire logic [3:0] third_port_read,
  input wire logic [7:0] first_port_line_in,
  input wire logic [7:0] first_port_line_out,
  input wire logic [7:0] first_port_line_oe,
  input wire logic [3:0] key_wakeup_input,
  input wire logic event_count_input,
  input wire logic pulse_width_input,
  input wire logic buzzer_enable,
  input wire logic buzzer_tone_output,
  input wire logic analog_input_zero_sel,
  input wire logic analog_input_one_sel,
  input wire logic remote_enable,
  input wire logic remote_carrier_output,
  input wire logic spi_sdi_in,
  input wire logic irq_request_b,
  input wire logic special_mode_select,
  input wire logic [24:0] lcd_front_plane,
  input wire logic [3:0] lcd_back_plane,
  input wire logic lcd_quarter_duty,
  input wire logic [15:0] lcd_front_plane_pin,
  input wire logic lcd_shared_plane_pin,
  input wire logic main_osc_input,
  input wire logic secondary_osc_input,
  input wire logic osc_select,
  input wire logic bus_frequency_clk
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [2:0] cnt_reg;
  wire per_off = !buzzer_enable && !remote_enable
    && !analog_input_zero_sel && !analog_input_one_sel;
  // edges since reset release, saturating
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_reg <= 3'h0;
    else if (cnt_reg != 3'h7)
      cnt_reg <= cnt_reg + 3'h1;
  end
  a_key_event_follow: assert property (
    key_wakeup_input == first_port_read[3:0] && event_count_input == first_port_read[4]
    && pulse_width_input == first_port_read[7]) else $error("first port feed wrong");
  a_sdi_irq_follow: assert property (
    spi_sdi_in == third_port_read[2] && irq_request_b == third_port_read[3])
    else $error("third port feed wrong");
  a_shared_plane_sel: assert property (
    lcd_shared_plane_pin == (lcd_quarter_duty ? lcd_back_plane[3] : lcd_front_plane[0]))
    else $error("shared plane pin wrong");
  a_front_plane_pins: assert property (lcd_front_plane_pin == lcd_front_plane[16:1])
    else $error("front plane pins wrong");
  a_buzz_drive: assert property (
    buzzer_enable |-> first_port_line_oe[3] && first_port_line_out[3] == buzzer_tone_output)
    else $error("buzzer not driving");
  a_remote_drive: assert property (
    remote_enable |-> first_port_line_oe[6] && first_port_line_out[6] == remote_carrier_output)
    else $error("carrier not driving");
  a_analog_float: assert property (analog_input_zero_sel |-> !first_port_line_oe[4])
    else $error("analog pin driven");
  a_dir_load: assert property (
    cfg_wr && cfg_sel == PFS_CFG_A_DIR && per_off ##1 per_off
    |-> first_port_line_oe == $past(cfg_wdata)) else $error("direction not loaded");
  a_read_sync: assert property (
    $stable(first_port_line_in)[*6] |-> first_port_read == first_port_line_in)
    else $error("port read not following pin");
  a_bus_clk_quiet: assert property (
    ((osc_select ? $stable(secondary_osc_input) : $stable(main_osc_input))
    && $stable(osc_select))[*8] |=> $stable(bus_frequency_clk))
    else $error("bus clock moved with osc still");
  a_mode_early: assert property (cnt_reg <= 3'h4 |-> !special_mode_select)
    else $error("mode set too early");
  a_mode_capture: assert property (
    cnt_reg == 3'h5 |-> special_mode_select == !$past(third_port_read[3]))
    else $error("mode capture wrong");
  a_mode_hold: assert property (cnt_reg > 3'h5 |-> $stable(special_mode_select))
    else $error("mode changed after capture");
endmodule
bind pfs_pin_mux pfs_pin_mux_asserts u_chk (.*);
`default_nettype wire

// [pfs_board_model.sv]
// board side: pin levels and two free running oscillators
`timescale 1ns/1ps
`default_nettype none
module pfs_board_model
(
  input wire logic [7:0] first_port_line_out,
  input wire logic [7:0] first_port_line_oe,
  input wire logic [7:0] a_ext,
  input wire logic [7:0] second_port_line_out,
  input wire logic [7:0] second_port_line_oe,
  input wire logic [7:0] b_ext,
  input wire logic [3:0] third_port_line_out,
  input wire logic [3:0] third_port_line_oe,
  input wire logic [3:0] third_port_pullup_en,
  input wire logic [3:0] c_ext,
  output logic [7:0] first_port_line_in,
  output logic [7:0] second_port_line_in,
  output logic [3:0] third_port_line_in,
  output logic main_osc_input,
  output logic secondary_osc_input
);
  assign first_port_line_in = (first_port_line_oe & first_port_line_out)
    | (~first_port_line_oe & a_ext);
  assign second_port_line_in = (second_port_line_oe & second_port_line_out)
    | (~second_port_line_oe & b_ext);
  // pull-up wins over the weak external source
  assign third_port_line_in = (third_port_line_oe & third_port_line_out)
    | (~third_port_line_oe & (third_port_pullup_en | c_ext));
  initial
  begin
    main_osc_input = 1'b0;
    forever #500 main_osc_input = ~main_osc_input;
  end
  initial
  begin
    secondary_osc_input = 1'b0;
    forever #850 secondary_osc_input = ~secondary_osc_input;
  end
endmodule
`default_nettype wire

// [pfs_pin_mux_tb_top.sv]
// self-checking bench for the pin function sharing block
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_mux_tb_top
  import pfs_pkg::*;
;
  logic ref_clk, rst_b, cfg_wr, buzzer_enable, buzzer_tone_output, analog_input_zero_sel;
  logic analog_input_one_sel, remote_enable, remote_carrier_output, spi_enable, spi_sck_out;
  logic spi_sck_oe, spi_sdo_out, spi_sdo_oe, irq_enable, lcd_quarter_duty, osc_select;
  logic main_osc_input, secondary_osc_input, event_count_input, pulse_width_input, spi_sdi_in;
  logic irq_request_b, special_mode_select, lcd_shared_plane_pin, bus_frequency_clk;
  pfs_cfg_t cfg_sel;
  logic [7:0] cfg_wdata, first_port_read, second_port_read, first_port_line_in, a_ext, b_ext;
  logic [7:0] first_port_line_out, first_port_line_oe, second_port_line_in, fp_rev;
  logic [7:0] second_port_line_out, second_port_line_oe;
  logic [3:0] third_port_read, third_port_line_in, third_port_line_out, third_port_line_oe;
  logic [3:0] third_port_pullup_en, key_wakeup_input, lcd_back_plane, c_ext;
  logic [24:0] lcd_front_plane;
  logic [15:0] lcd_front_plane_pin;
  logic [2:0] lcd_back_plane_pin;
  int n_fail, n_checks, n_bus;
  pfs_pin_mux dut (.*);
  pfs_board_model board (.*);
  assign fp_rev = {<<{lcd_front_plane[24:17]}};
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge bus_frequency_clk) n_bus++;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic cfg(input pfs_cfg_t s, input logic [7:0] d);
    cfg_wr <= 1'b1;
    cfg_sel <= s;
    cfg_wdata <= d;
    tick(1);
    cfg_wr <= 1'b0;
    tick(1);
  endtask
  task automatic do_reset(input logic [3:0] c);
    rst_b <= 1'b0;
    c_ext <= c;
    tick(8);
    rst_b <= 1'b1;
    tick(12);
    @(negedge ref_clk);
    chk("a oe", first_port_line_oe, 8'h00);
    chk("c oe", third_port_line_oe, 4'h0);
    chk("pull", third_port_pullup_en, 4'h0);
    chk("b oe", second_port_line_oe, 8'hff);
    chk("b lcd", second_port_line_out, fp_rev);
    chk("mode", special_mode_select, !c[3]);
    tick(1);
    $display("reset test done");
  endtask
  task automatic t_first;
    cfg(PFS_CFG_A_DATA, 8'h5a);
    cfg(PFS_CFG_A_DIR, 8'hf0);
    tick(7);
    @(negedge ref_clk);
    chk("a oe", first_port_line_oe, 8'hf0);
    chk("a read", first_port_read, 8'h5c);
    chk("key", key_wakeup_input, 4'hc);
    chk("event", event_count_input, 1'b1);
    tick(1);
    buzzer_enable <= 1'b1;
    buzzer_tone_output <= 1'b1;
    remote_enable <= 1'b1;
    analog_input_zero_sel <= 1'b1;
    analog_input_one_sel <= 1'b1;
    @(negedge ref_clk);
    chk("a oe ovr", first_port_line_oe, 8'hc8);
    chk("a out ovr", first_port_line_out & 8'h48, 8'h08);
    tick(1);
    {buzzer_enable, remote_enable, analog_input_zero_sel, analog_input_one_sel} <= 4'h0;
    $display("first port test done");
  endtask
  task automatic t_third;
    c_ext <= 4'h0;
    cfg(PFS_CFG_C_PULL, 8'h05);
    cfg(PFS_CFG_OD, 8'h01);
    {spi_enable, spi_sck_oe, spi_sdo_out, spi_sdo_oe, irq_enable} <= 5'h1f;
    @(negedge ref_clk);
    chk("pull", third_port_pullup_en, 4'h5);
    chk("c oe", third_port_line_oe, 4'h3);
    chk("c out", third_port_line_out & 4'h3, 4'h2);
    tick(1);
    spi_sck_out <= 1'b1;
    @(negedge ref_clk);
    chk("sck od", third_port_line_oe, 4'h2);
    tick(6);
    @(negedge ref_clk);
    chk("c read", third_port_read, 4'h7);
    chk("sdi", spi_sdi_in, 1'b1);
    chk("irq", irq_request_b, 1'b0);
    tick(1);
    {spi_enable, irq_enable} <= 2'h0;
    $display("third port test done");
  endtask
  task automatic t_second;
    cfg(PFS_CFG_B_LCD, 8'h0f);
    cfg(PFS_CFG_B_DIR, 8'hff);
    cfg(PFS_CFG_B_DATA, 8'h96);
    lcd_quarter_duty <= 1'b1;
    tick(6);
    @(negedge ref_clk);
    chk("b out", second_port_line_out, 8'h90 | (fp_rev & 8'h0f));
    chk("b read", second_port_read, 8'h90 | (fp_rev & 8'h0f));
    chk("shared bp", lcd_shared_plane_pin, lcd_back_plane[3]);
    chk("bp pins", lcd_back_plane_pin, lcd_back_plane[2:0]);
    tick(1);
    lcd_quarter_duty <= 1'b0;
    @(negedge ref_clk);
    chk("shared fp", lcd_shared_plane_pin, lcd_front_plane[0]);
    tick(1);
    $display("second port test done");
  endtask
  task automatic t_clock;
    for (int s = 0; s < 2; s++)
    begin
      int e;
      int n0;
      e = 34000 / (s ? 3400 : 2000);
      osc_select <= s[0];
      tick(20);
      n0 = n_bus;
      tick(680);
      n0 = n_bus - n0;
      chk("bus rate", n0 >= e - 1 && n0 <= e + 1, 1'b1);
    end
    $display("bus clock test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    {rst_b, cfg_wr, buzzer_enable, buzzer_tone_output, analog_input_zero_sel, remote_enable,
      analog_input_one_sel, remote_carrier_output, spi_enable, spi_sck_out, spi_sck_oe,
      spi_sdo_out, spi_sdo_oe, irq_enable, lcd_quarter_duty, osc_select} = '0;
    cfg_sel = PFS_CFG_A_DATA;
    cfg_wdata = 8'h00;
    a_ext = 8'h3c;
    b_ext = 8'h00;
    c_ext = 4'hf;
    lcd_front_plane = 25'h1a5c3e8;
    lcd_back_plane = 4'h9;
    do_reset(4'hf);
    t_first;
    t_third;
    t_second;
    t_clock;
    do_reset(4'h0);
    close_out;
  end
  initial
  begin
    #1000000;
    n_fail++;
    close_out;
  end
endmodule
`default_nettype wire
